// File: logic/evs_pkg.sv
// Package: constants and carriers of the exception, vector and stack unit
package evs_pkg;
   localparam logic [31:0] VEC_BASE_RST = 32'h0000_0000;
   localparam logic [31:0] OFS_INIT_SP = 32'h0000_0000;
   localparam logic [31:0] OFS_INIT_PC = 32'h0000_0004;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam int VEC_TABLE_BYTES = 196;
   localparam int NUM_IRQ = 32;
   localparam int NUM_PRIO = 4;
   localparam int CTX_WORDS = 8;
   localparam logic [4:0] ENTRY_CYC = 5'h0f;
   localparam logic [4:0] CHAIN_CYC = 5'h0b;
   // Exception numbers
   localparam logic [5:0] EXC_NMI = 6'h02;
   localparam logic [5:0] EXC_FAULT = 6'h03;
   localparam logic [5:0] EXC_SVC = 6'h0b;
   localparam logic [5:0] EXC_IRQ0 = 6'h10;
   // Active levels: 0 nmi, 1 fault, 2..5 priority 0..3, 6 means thread
   localparam logic [2:0] LVL_NMI = 3'h0;
   localparam logic [2:0] LVL_FAULT = 3'h1;
   localparam logic [2:0] LVL_PRIO0 = 3'h2;
   localparam logic [2:0] LVL_NONE = 3'h6;
   localparam logic [31:0] ALIGN_HALF = 32'hffff_fffe;
   localparam logic [31:0] ALIGN_WORD = 32'hffff_fffc;

   typedef enum logic [6:0] {
      ST_BSP = 7'h01, ST_BPC = 7'h02, ST_RUN = 7'h04, ST_PUSH = 7'h08,
      ST_VEC = 7'h10, ST_POP = 7'h20, ST_WAIT = 7'h40
   } evs_state_t;

   // Word-only memory request
   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } evs_mem_t;

   typedef struct packed {
      evs_state_t st;
      evs_mem_t mem;
      logic [31:0] sp;
      logic [31:0] base;
      logic [31:0] pc;
      logic pcLoad;
      logic [CTX_WORDS-1:0][31:0] ctx;
      logic ctxLoad;
      logic [2:0] cnt;
      logic [4:0] cyc;
      logic [4:0] target;
      logic [5:0] excNum;
      logic [5:0] active;
      logic [5:0][5:0] excOf;
      logic [NUM_IRQ-1:0] irqPend;
      logic nmiPend;
      logic faultPend;
      logic svcPend;
      logic primask;
      logic unpriv;
      logic handler;
      logic priv;
      logic exitSeq;
      logic hold;
   } evs_state_bundle_t;
endpackage : evs_pkg

// File: logic/evs_exception_unit.sv
// Exception entry, return, vector fetch and stack handling for the core
// Contract
// RL1: Vector base is zero after reset; software may move it to flash or RAM.
// RL2: Reset loads stack pointer from table word 0, program counter from word 4.
// RL3: Stack pointer load at reset is done by hardware, no instructions used.
// RL4: Full-descending stack: decrement pointer, then store each word.
// RL5: Every stack access, saving and restoring included, is a 32-bit word.
// RL6: Thread mode runs applications; exceptions switch to handler mode.
// RL7: Handler always privileged; thread privileged unless configured otherwise.
// RL8: Unprivileged code cannot mask or unmask interrupts.
// RL9: Up to 32 peripheral interrupt request inputs.
// RL10: Four priority levels; more urgent request preempts in hardware.
// RL11: Non-maskable input plus severe-error and supervisor-call exceptions.
// RL12: Entry and return, context save and restore, done wholly in hardware.
// RL13: Table entries beyond the first hold handler addresses; core branches there.
// RL14: Software relocates vectors by writing the vector base register.
// RL15: Vectors occupy the first 196 bytes from address zero by default.
// RL16: Instructions are 16 or 32 bits with no trailing operand data.
// RL17: Priority 0 is most urgent, 3 least.
// RL18: Entry or exit takes 15 cycles; tail-chained exit and re-entry 11.
// RL19: Vector address is table base plus four times exception number.
`timescale 1ns/1ns
module evs_exception_unit #(
   parameter int NUM_IRQ = evs_pkg::NUM_IRQ
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Peripheral interrupt sources
   input wire logic [NUM_IRQ-1:0] irqReq,
   input wire logic [NUM_IRQ-1:0] irqEnable,
   input wire logic [NUM_IRQ-1:0][1:0] irqPrio,
   input wire logic nmiReq,
   // Core requests
   input wire logic faultReq,
   input wire logic svcReq,
   input wire logic excReturn,
   input wire logic maskSet,
   input wire logic maskClr,
   input wire logic unprivWr,
   input wire logic unprivIn,
   input wire logic vecBaseWr,
   input wire logic [31:0] vecBaseIn,
   input wire logic [evs_pkg::CTX_WORDS-1:0][31:0] ctxIn,
   // Core results
   output logic [31:0] pcOut,
   output logic pcLoad,
   output logic [31:0] spOut,
   output logic [evs_pkg::CTX_WORDS-1:0][31:0] ctxOut,
   output logic ctxLoad,
   output logic coreHold,
   output logic handlerMode,
   output logic privileged,
   output logic primask,
   output logic [5:0] curExc,
   // Memory holding vectors and stack
   output evs_pkg::evs_mem_t memOut,
   input wire logic memAck,
   input wire logic [31:0] memRdata
);
   evs_pkg::evs_state_bundle_t q, d;

   // Index of the most urgent active level, LVL_NONE when idle
   function automatic logic [2:0] lowBit(input logic [5:0] v);
      logic [2:0] r;
      r = evs_pkg::LVL_NONE;
      for (int i = 5; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : lowBit

   // Most urgent pending request; ties go to lower number
   logic bestHit;
   logic [2:0] bestLvl;
   logic [5:0] bestExc;
   logic [NUM_IRQ-1:0] bestClr;
   always_comb begin
      bestHit = 1'b0;
      bestLvl = evs_pkg::LVL_NONE;
      bestExc = 6'h00;
      bestClr = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (q.irqPend[i] && !q.primask
             && (evs_pkg::LVL_PRIO0 + {1'b0, irqPrio[i]}) <= bestLvl) begin // RL17
            bestHit = 1'b1;
            bestLvl = evs_pkg::LVL_PRIO0 + {1'b0, irqPrio[i]};
            bestExc = evs_pkg::EXC_IRQ0 + 6'(i);
            bestClr = '0;
            bestClr[i] = 1'b1;
         end
      end
      if (q.svcPend) begin // RL11
         bestHit = 1'b1;
         bestLvl = evs_pkg::LVL_PRIO0;
         bestExc = evs_pkg::EXC_SVC;
         bestClr = '0;
      end
      if (q.faultPend) begin
         bestHit = 1'b1;
         bestLvl = evs_pkg::LVL_FAULT;
         bestExc = evs_pkg::EXC_FAULT;
         bestClr = '0;
      end
      if (q.nmiPend) begin // RL11
         bestHit = 1'b1;
         bestLvl = evs_pkg::LVL_NMI;
         bestExc = evs_pkg::EXC_NMI;
         bestClr = '0;
      end
   end

   logic [2:0] curLvl;
   logic [5:0] afterRet;
   logic [2:0] retLvl;
   logic take;
   logic chain;
   logic grab;
   assign curLvl = lowBit(q.active);
   assign afterRet = q.active & ~(6'h01 << curLvl);
   assign retLvl = lowBit(afterRet);
   // Preempt only a less urgent level; nested entries stack in hardware
   assign take = (q.st == evs_pkg::ST_RUN) && bestHit && bestLvl < curLvl; // RL10
   assign chain = bestHit && bestLvl < retLvl;
   assign grab = take || ((q.st == evs_pkg::ST_RUN) && excReturn && q.handler && chain);

   // Next state
   always_comb begin
      d = q;
      d.pcLoad = 1'b0;
      d.ctxLoad = 1'b0;
      d.cyc = q.cyc + 5'h01;
      // Pending flags: a new request wins over the clear of a taken one
      d.irqPend = (q.irqPend & ~(grab ? bestClr : {NUM_IRQ{1'b0}})) | (irqReq & irqEnable); // RL9
      d.nmiPend = nmiReq | (q.nmiPend && !(grab && bestExc == evs_pkg::EXC_NMI)); // RL11
      d.faultPend = faultReq | (q.faultPend && !(grab && bestExc == evs_pkg::EXC_FAULT));
      d.svcPend = svcReq | (q.svcPend && !(grab && bestExc == evs_pkg::EXC_SVC));
      if (vecBaseWr) begin
         d.base = vecBaseIn & evs_pkg::ALIGN_WORD; // RL14
      end
      // Unprivileged code may not touch the mask or the privilege setting
      if (q.priv) begin // RL8
         if (maskSet) begin
            d.primask = 1'b1;
         end else if (maskClr) begin
            d.primask = 1'b0;
         end
         if (unprivWr) begin
            d.unpriv = unprivIn; // RL7
         end
      end
      case (q.st)
         evs_pkg::ST_BSP: begin
            if (memAck) begin
               d.sp = memRdata & evs_pkg::ALIGN_WORD; // RL3
               d.st = evs_pkg::ST_BPC;
            end
         end
         evs_pkg::ST_BPC: begin
            if (memAck) begin
               d.pc = memRdata & evs_pkg::ALIGN_HALF; // RL16
               d.pcLoad = 1'b1;
               d.st = evs_pkg::ST_RUN;
            end
         end
         evs_pkg::ST_RUN: begin
            d.cyc = 5'h00;
            if (take) begin
               d.ctx = ctxIn;
               d.excNum = bestExc;
               d.active[bestLvl] = 1'b1;
               d.excOf[bestLvl] = bestExc;
               d.handler = 1'b1; // RL6
               d.target = evs_pkg::ENTRY_CYC; // RL18
               d.cnt = 3'h0;
               d.exitSeq = 1'b0;
               d.st = evs_pkg::ST_PUSH; // RL12
            end else if (excReturn && q.handler) begin
               d.active = afterRet;
               d.cnt = 3'h0;
               if (chain) begin
                  // Tail-chain: context stays on the stack, only the vector moves
                  d.excNum = bestExc;
                  d.active[bestLvl] = 1'b1;
                  d.excOf[bestLvl] = bestExc;
                  d.target = evs_pkg::CHAIN_CYC; // RL18
                  d.exitSeq = 1'b0;
                  d.st = evs_pkg::ST_VEC;
               end else begin
                  d.target = evs_pkg::ENTRY_CYC; // RL18
                  d.exitSeq = 1'b1;
                  d.st = evs_pkg::ST_POP; // RL12
               end
            end
         end
         evs_pkg::ST_PUSH: begin
            if (memAck) begin
               d.sp = q.sp - evs_pkg::WORD_BYTES; // RL4
               d.cnt = q.cnt + 3'h1;
               if (q.cnt == 3'(evs_pkg::CTX_WORDS - 1)) begin
                  d.st = evs_pkg::ST_VEC;
               end
            end
         end
         evs_pkg::ST_VEC: begin
            if (memAck) begin
               d.pc = memRdata & evs_pkg::ALIGN_HALF; // RL13
               d.st = evs_pkg::ST_WAIT;
            end
         end
         evs_pkg::ST_POP: begin
            if (memAck) begin
               d.ctx[3'(evs_pkg::CTX_WORDS - 1) - q.cnt] = memRdata; // RL5 RL12
               d.sp = q.sp + evs_pkg::WORD_BYTES;
               d.cnt = q.cnt + 3'h1;
               if (q.cnt == 3'(evs_pkg::CTX_WORDS - 1)) begin
                  d.st = evs_pkg::ST_WAIT;
               end
            end
         end
         evs_pkg::ST_WAIT: begin
            // Pad so that latency does not depend on memory speed when fast
            if (q.cyc >= q.target - 5'h01) begin // RL18
               d.st = evs_pkg::ST_RUN;
               if (q.exitSeq) begin
                  d.ctxLoad = 1'b1;
                  d.handler = (retLvl != evs_pkg::LVL_NONE) || (q.active != 6'h00);
                  d.excNum = (q.active == 6'h00) ? 6'h00 : q.excOf[curLvl];
               end else begin
                  d.pcLoad = 1'b1;
               end
            end
         end
         default: begin
            d.st = evs_pkg::ST_BSP;
         end
      endcase
      d.priv = d.handler | ~d.unpriv; // RL7
      d.hold = (d.st != evs_pkg::ST_RUN); // RL12
      // Next memory access follows from the next state; word-only transfers
      d.mem = '0;
      case (d.st)
         evs_pkg::ST_BSP: begin
            d.mem.req = 1'b1;
            d.mem.addr = d.base + evs_pkg::OFS_INIT_SP; // RL2
         end
         evs_pkg::ST_BPC: begin
            d.mem.req = 1'b1;
            d.mem.addr = d.base + evs_pkg::OFS_INIT_PC; // RL2
         end
         evs_pkg::ST_PUSH: begin
            d.mem.req = 1'b1;
            d.mem.we = 1'b1;
            d.mem.addr = d.sp - evs_pkg::WORD_BYTES; // RL4
            d.mem.wdata = d.ctx[d.cnt]; // RL5
         end
         evs_pkg::ST_VEC: begin
            d.mem.req = 1'b1;
            d.mem.addr = d.base + {24'h000000, d.excNum, 2'b00}; // RL19
         end
         evs_pkg::ST_POP: begin
            d.mem.req = 1'b1;
            d.mem.addr = d.sp;
         end
         default: d.mem = '0;
      endcase
   end

   // State register; fetch of the boot words starts right after reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= evs_pkg::ST_BSP; // RL3
         q.base <= evs_pkg::VEC_BASE_RST; // RL1 RL15
         q.mem.req <= 1'b1;
         q.mem.addr <= evs_pkg::VEC_BASE_RST + evs_pkg::OFS_INIT_SP;
         q.priv <= 1'b1;
         q.hold <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign pcOut = q.pc;
   assign pcLoad = q.pcLoad;
   assign spOut = q.sp;
   assign ctxOut = q.ctx;
   assign ctxLoad = q.ctxLoad;
   assign coreHold = q.hold;
   assign handlerMode = q.handler;
   assign privileged = q.priv;
   assign primask = q.primask;
   assign curExc = q.excNum;
   assign memOut = q.mem;
endmodule : evs_exception_unit

// File: tb/evs_mem_model.sv
// Memory model holding the vector table and the stack
`timescale 1ns/1ns
module evs_mem_model (
   // Clock
   input wire logic clk_sys,
   // Request side
   input wire evs_pkg::evs_mem_t memOut,
   input wire logic slow,
   // Answer side
   output logic memAck,
   output logic [31:0] memRdata
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] lastQ = 32'h0;
   logic odd = 1'h0;
   // Unwritten words read as a handler address made from the address
   function automatic logic [31:0] rd(input logic [31:0] a);
      if (mem.exists(a)) return mem[a];
      return {a[15:0], 16'h0001};
   endfunction : rd
   // Boot pair with low bits set, so the design must clear them
   initial begin
      mem[32'h0] = 32'h2000_0403;
      mem[32'h4] = 32'h0000_0101;
   end
   // Slow mode answers every other cycle
   assign memAck = memOut.req && (!slow || odd);
   // Idle data bus shows the inverse of the last word
   assign memRdata = (memAck && !memOut.we) ? rd(memOut.addr) : ~lastQ;
   always @(posedge clk_sys) begin
      odd <= !odd;
      if (memAck && memOut.we) mem[memOut.addr] = memOut.wdata;
      lastQ <= memRdata;
   end
endmodule : evs_mem_model

// File: tb/evs_exception_unit_asserts.sv
// Checker of the exception unit ports
`timescale 1ns/1ns
module evs_exception_unit_asserts #(
   parameter int NUM_IRQ = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Watched signals
   input wire logic maskSet,
   input wire logic maskClr,
   input wire logic memAck,
   input wire evs_pkg::evs_mem_t memOut,
   input wire logic [31:0] pcOut,
   input wire logic pcLoad,
   input wire logic coreHold,
   input wire logic handlerMode,
   input wire logic privileged,
   input wire logic primask
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_boot; $rose(reset_n) |-> memOut.req && memOut.addr == 32'h0 && coreHold; endproperty
   a_boot: assert property (p_boot) else $error("boot read not at zero");
   property p_word; memOut.req |-> memOut.addr[1:0] == 2'h0; endproperty
   a_word: assert property (p_word) else $error("access not word aligned");
   property p_hold; memOut.req && !memAck |=> $stable(memOut); endproperty
   a_hold: assert property (p_hold) else $error("request changed before ack");
   property p_desc; (memOut.req && memOut.we && memAck) ##1 (memOut.req && memOut.we)
      |-> memOut.addr == $past(memOut.addr) - 32'h4; endproperty
   a_desc: assert property (p_desc) else $error("push not descending");
   property p_hpriv; handlerMode |-> privileged; endproperty
   a_hpriv: assert property (p_hpriv) else $error("handler unprivileged");
   property p_even; pcLoad |-> !pcOut[0] && !coreHold; endproperty
   a_even: assert property (p_even) else $error("branch odd or held");
   property p_umask; !privileged && (maskSet || maskClr) |=> primask == $past(primask); endproperty
   a_umask: assert property (p_umask) else $error("mask changed unprivileged");
   property p_entry; $rose(handlerMode) |-> (!pcLoad)[*8] ##1 (!pcLoad)[*6] ##[1:600] pcLoad;
   endproperty
   a_entry: assert property (p_entry) else $error("entry length wrong");
   property p_coreh; $rose(handlerMode) |-> coreHold; endproperty
   a_coreh: assert property (p_coreh) else $error("core not held on entry");
endmodule : evs_exception_unit_asserts

bind evs_exception_unit evs_exception_unit_asserts #(.NUM_IRQ(NUM_IRQ)) u_chk (.*);

// File: tb/tb_evs_exception_unit.sv
// Self-checking bench of the exception unit
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module tb_evs_exception_unit;
   typedef struct packed {logic [2:0] k; logic [4:0] i; logic [5:0] exc;} evs_row_t;
   logic clk_sys = 1'h0;
   logic reset_n = 1'h0;
   logic [31:0] irqReq = 32'h0;
   logic [31:0] irqEnable = 32'hffff_ffff;
   logic [31:0][1:0] irqPrio = {32{2'h3}};
   logic nmiReq = 1'h0, faultReq = 1'h0, svcReq = 1'h0, excReturn = 1'h0;
   logic maskSet = 1'h0, maskClr = 1'h0, unprivWr = 1'h0, unprivIn = 1'h0;
   logic vecBaseWr = 1'h0, slow = 1'h0, pcLoad, ctxLoad, coreHold;
   logic handlerMode, privileged, primask, memAck;
   logic [31:0] vecBaseIn = 32'h0, pcOut, spOut, memRdata;
   logic [evs_pkg::CTX_WORDS-1:0][31:0] ctxIn, ctxOut, ctxKeep;
   logic [5:0] curExc;
   evs_pkg::evs_mem_t memOut;
   int n_errors = 0, compares = 0, cnt;
   evs_row_t rows [5] = '{'{3'h0, 5'h0, 6'h02}, '{3'h1, 5'h0, 6'h03}, '{3'h2, 5'h0, 6'h0b},
      '{3'h3, 5'h0, 6'h10}, '{3'h3, 5'h1f, 6'h2f}};
   evs_exception_unit dut_u (.*);
   evs_mem_model mem_u (.*);
   always #50 clk_sys = ~clk_sys;
   function automatic logic [31:0] hand(input logic [31:0] a);
      return {a[15:0], 16'h0000};
   endfunction : hand
   // One-cycle request pulse from the falling edge
   task automatic pulse(input int k, input int i);
      @(negedge clk_sys);
      case (k)
         0: nmiReq = 1'h1;
         1: faultReq = 1'h1;
         2: svcReq = 1'h1;
         3: irqReq[i] = 1'h1;
         4: excReturn = 1'h1;
         5: maskSet = 1'h1;
         default: maskClr = 1'h1;
      endcase
      @(negedge clk_sys);
      {nmiReq, faultReq, svcReq, excReturn, maskSet, maskClr, unprivWr, vecBaseWr} = 8'h0;
      irqReq = 32'h0;
   endtask : pulse
   // Bounded wait for a branch or a restore, counting cycles
   task automatic waitLoad(input logic ctx);
      cnt = 1;
      while (((ctx ? ctxLoad : pcLoad) !== 1'h1) && cnt < 300) begin
         @(negedge clk_sys);
         cnt++;
      end
      `CHK("wait", 1'h1, cnt < 300)
   endtask : waitLoad
   task automatic summarize();
      $display("Checks %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   // Watchdog well beyond the expected run
   initial begin
      #(100 * 8000);
      n_errors++;
      summarize();
   end
   initial begin
      // Fixed context pattern, so a restored word shows where it came from
      foreach (ctxIn[i]) ctxIn[i] = 32'hc0de_0000 + i;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'h1;
      waitLoad(1'h0);
      `CHK("bootsp", 32'h2000_0400, spOut)
      `CHK("bootpc", 32'h0000_0100, pcOut)
      `CHK("bootcyc", 1'h1, cnt <= 5)
      `CHK("boothold", 1'h0, coreHold)
      `CHK("bootmode", 3'h2, {handlerMode, privileged, primask})
      foreach (rows[r]) begin
         slow = (r == 4);
         pulse(rows[r].k, rows[r].i);
         waitLoad(1'h0);
         `CHK("entry", 1'h1, cnt >= 15)
         `CHK("exc", rows[r].exc, curExc)
         `CHK("vec", hand({24'h0, rows[r].exc, 2'h0}), pcOut)
         `CHK("mode", 2'h3, {handlerMode, privileged})
         `CHK("spin", 32'h2000_03e0, spOut)
         pulse(4, 0);
         waitLoad(1'h1);
         `CHK("ctx", ctxIn, ctxOut)
         `CHK("thr", 2'h1, {handlerMode, privileged})
         `CHK("sp", 32'h2000_0400, spOut)
         $display("Test row %0d done", r);
      end
      slow = 1'h0;
      // Three at once, then a preempting one inside the last
      irqPrio[7] = 2'h1;
      irqPrio[3] = 2'h2;
      irqPrio[5] = 2'h2;
      irqReq = 32'h0000_00a8;
      // One cycle only, so a taken source does not pend again
      @(negedge clk_sys);
      irqReq = 32'h0;
      waitLoad(1'h0);
      `CHK("urgent", 6'h17, curExc)
      pulse(4, 0);
      waitLoad(1'h0);
      `CHK("chain", 1'h1, cnt >= 11)
      `CHK("tie", 6'h13, curExc)
      pulse(4, 0);
      waitLoad(1'h0);
      `CHK("next", 6'h15, curExc)
      // New context for the nested entry; the outer one must come back from the stack
      ctxKeep = ctxIn;
      ctxIn = ~ctxIn;
      pulse(3, 7);
      waitLoad(1'h0);
      `CHK("nest", 6'h17, curExc)
      pulse(4, 0);
      waitLoad(1'h1);
      `CHK("back", 6'h15, curExc)
      pulse(4, 0);
      waitLoad(1'h1);
      `CHK("outer", ctxKeep, ctxOut)
      $display("Test priority done");
      // Masking, then unprivileged thread
      pulse(5, 0);
      pulse(3, 1);
      repeat (20) @(negedge clk_sys);
      `CHK("masked", 1'h0, handlerMode)
      unprivWr = 1'h1;
      unprivIn = 1'h1;
      pulse(6, 0);
      `CHK("unpriv", 2'h1, {privileged, primask})
      pulse(0, 0);
      waitLoad(1'h0);
      `CHK("nmi", 2'h3, {handlerMode, privileged})
      pulse(6, 0);
      `CHK("clr", 1'h0, primask)
      pulse(4, 0);
      waitLoad(1'h0);
      `CHK("irq1", 6'h11, curExc)
      pulse(4, 0);
      waitLoad(1'h1);
      `CHK("thru", 2'h0, {handlerMode, privileged})
      $display("Test privilege done");
      // Relocated table, then a reset puts the base back
      vecBaseIn = 32'h0000_4000;
      vecBaseWr = 1'h1;
      pulse(2, 0);
      waitLoad(1'h0);
      `CHK("reloc", hand(32'h0000_402c), pcOut)
      reset_n = 1'h0;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'h1;
      waitLoad(1'h0);
      `CHK("rstpc", 32'h0000_0100, pcOut)
      `CHK("rstmode", 2'h1, {handlerMode, privileged})
      $display("Test relocation done");
      summarize();
   end
endmodule : tb_evs_exception_unit
